// *** hpio_hs_chan.sv ***
// One strobed handshake channel: input latch, output latch flag and service request
`timescale 1ns/1ps
module hpio_hs_chan
	import hpio_pkg::*;
#(
	parameter int W = PORT_WIDTH
)
(
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         inMode,
	input  wire logic         outMode,
	input  wire logic         inIe,
	input  wire logic         outIe,
	input  wire logic         strobeN,
	input  wire logic         acceptN,
	input  wire logic [W-1:0] pinData,
	input  wire logic         hostRead,
	input  wire logic         hostWrite,
	input  wire logic         clear,
	output logic      [W-1:0] latchData,
	output logic              inFull,
	output logic              outFullN,
	output logic              servReq
);

	hpio_hs_state_t s_q;
	hpio_hs_state_t s_d;

	////////////////////////////////////////////////////////////////////////////////
	// Next state; a strobe edge beats a host read in the same cycle
	always_comb
	begin
		s_d = s_q;
		s_d.strobePrev = strobeN;
		if (inMode && !strobeN && s_q.strobePrev)
		begin
			s_d.latch  = pinData;
			s_d.inFull = 1'b1;
		end
		else if (hostRead)
		begin
			s_d.inFull = 1'b0;
		end
		if (outMode && hostWrite)
		begin
			s_d.outFullN = 1'b0;
		end
		else if (outMode && !acceptN)
		begin
			s_d.outFullN = 1'b1;
		end
		// Request only while the matching enable is set
		s_d.servReq = (inMode && inIe && s_d.inFull && strobeN)
			|| (outMode && outIe && s_d.outFullN && acceptN);
		if (clear)
		begin
			s_d = HS_RESET;
		end
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (rst)
			s_q <= HS_RESET;
		else
			s_q <= s_d;
	end

	assign latchData = s_q.latch;
	assign inFull    = s_q.inFull;
	assign outFullN  = s_q.outFullN;
	assign servReq   = s_q.servReq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the handshake sequence
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence strobeFall;
		inMode && !clear && !strobeN && $past(strobeN);
	endsequence

	a_strobe_latch: assert property (strobeFall |=> inFull && latchData == $past(pinData))
		else $error("strobe did not fill the input latch");
	a_write_full: assert property (outMode && hostWrite && !clear |=> !outFullN)
		else $error("host write did not lower output full");
	a_accept_empty: assert property (outMode && !acceptN && !hostWrite && !clear |=> outFullN)
		else $error("accept did not release output full");
	a_req_enabled: assert property (servReq |-> $past(inIe) || $past(outIe))
		else $error("service request without enable");

endmodule : hpio_hs_chan

// *** hpio_peer.sv ***
// External device model on the port pins: drives data and strobes, answers first port output handshakes
`timescale 1ns/1ps
module hpio_peer
	import hpio_pkg::*;
(
	input  wire logic       mclk,
	input  wire hpio_pins_t pinOut,
	input  wire hpio_pins_t pinOeN,
	input  wire hpio_pins_t drive,
	input  wire logic [3:0] ackDelay,
	output hpio_pins_t      pinIn
);
	logic [23:0] ext;
	logic [23:0] lvl;
	logic [3:0]  cnt;
	logic        ackN;

	////////////////////////////////////////////////////////////////////////////////
	// Wire level: the block wins where it drives; the lines have no pulls
	assign ext   = {drive[23:7], ackN, drive[5:0]};
	assign lvl   = (pinOeN & ext) | (~pinOeN & pinOut);
	assign pinIn = hpio_pins_t'(lvl);

	// Accept after a chosen delay so both prompt and slow receivers are seen
	initial
	begin
		cnt  = 4'h0;
		ackN = 1'b1;
	end
	always @(posedge mclk)
	begin
		if (lvl[C_A_OLF])
		begin
			cnt  <= 4'h0;
			ackN <= 1'b1; // Idle high
		end
		else if (cnt == ackDelay)
			ackN <= 1'b0; // Held low until the full flag clears
		else
			cnt <= cnt + 4'h1;
	end
endmodule : hpio_peer

// *** hpio_pkg.sv ***
// Shared constants, field layouts and carrier types of the handshake parallel I/O block
// Behaviour
// - The block offers 24 digital lines, each of which software can make an input or an output.
// - The lines form three 8-bit ports, first_port, second_port and third_port, bits 0 to 7.
// - One configuration register holds every direction and mode, and writing it resets all ports and clears their output data.
// - In basic mode all third_port lines are plain I/O, as two 4-bit halves with their own direction.
// - In the handshake modes third_port carries handshake and status lines, leaving zero, two, three or five lines free.
// - Strobed input uses third_port bits 5 to 0 as input_latch_full A, load_strobe_n A, service_request A, load_strobe_n B, input_latch_full B, service_request B.
// - Strobed output uses bits 7 and 6 as output_latch_full_n A and peer_accept_n A, bits 3 to 0 as service_request A, peer_accept_n B, output_latch_full_n B, service_request B.
// - Bidirectional mode uses bits 7 to 3 as output_latch_full_n, peer_accept_n, input_latch_full, load_strobe_n and service_request of first_port, bits 2 to 0 stay I/O.
// - load_strobe_n, peer_accept_n and output_latch_full_n are active low, input_latch_full and service_request active high.
// - A low load_strobe_n captures port data into the input latch and the block then raises input_latch_full.
// - After a host write to a handshaking port the block drives output_latch_full_n low.
// - service_request goes high when a handshake transfer needs service, only while its enable is set.
package hpio_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and register offsets
	localparam int          PORT_WIDTH   = 8;
	localparam int          ADDR_WIDTH   = 3;
	localparam int          IRQ_WIDTH    = 2;
	localparam int          HSEN_WIDTH   = 3;
	localparam logic [2:0]  ADDR_FIRST   = 3'h0;
	localparam logic [2:0]  ADDR_SECOND  = 3'h1;
	localparam logic [2:0]  ADDR_THIRD   = 3'h2;
	localparam logic [2:0]  ADDR_CONFIG  = 3'h3;
	localparam logic [2:0]  ADDR_IRQSTAT = 3'h4;
	localparam logic [2:0]  ADDR_IRQCLR  = 3'h5;
	localparam logic [2:0]  ADDR_IRQEN   = 3'h6;
	localparam logic [2:0]  ADDR_HSEN    = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration word and modes of the first port group
	typedef struct packed {
		logic       spare;
		logic [1:0] aMode;
		logic       aIn;
		logic       cHiIn;
		logic       bMode;
		logic       bIn;
		logic       cLoIn;
	} hpio_cfg_t;

	localparam hpio_cfg_t  CFG_RESET    = 8'h9b;
	localparam logic [1:0] MODE_BASIC   = 2'h0;
	localparam logic [1:0] MODE_STROBED = 2'h1;
	localparam logic [1:0] MODE_BIDIR   = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Third port bit positions and masks of the handshake lines
	localparam int         C_A_OLF   = 7;
	localparam int         C_A_ACK   = 6;
	localparam int         C_A_ILF   = 5;
	localparam int         C_A_STB   = 4;
	localparam int         C_A_SRQ   = 3;
	localparam int         C_B_STRB  = 2;
	localparam int         C_B_FULL  = 1;
	localparam int         C_B_SRQ   = 0;
	localparam logic [7:0] MASK_A_IN  = 8'h38;
	localparam logic [7:0] MASK_A_OUT = 8'hc8;
	localparam logic [7:0] MASK_A_BI  = 8'hf8;
	localparam logic [7:0] MASK_B     = 8'h07;
	localparam logic [7:0] HS_DRIVEN  = 8'hab;
	localparam logic [7:0] PORT_ALL   = 8'hff;
	localparam int         HALF_WIDTH = 4;

	// Interrupt and handshake enable bits
	localparam int IRQ_A      = 0;
	localparam int IRQ_B      = 1;
	localparam int HSEN_A_IN  = 0;
	localparam int HSEN_A_OUT = 1;
	localparam int HSEN_B     = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers and state records
	typedef struct packed {
		logic [7:0] first;
		logic [7:0] second;
		logic [7:0] third;
	} hpio_pins_t;

	typedef struct packed {
		logic [7:0] latch;
		logic       inFull;
		logic       outFullN;
		logic       strobePrev;
		logic       servReq;
	} hpio_hs_state_t;

	localparam hpio_hs_state_t HS_RESET = '{latch: 8'h00, inFull: 1'b0, outFullN: 1'b1,
		strobePrev: 1'b1, servReq: 1'b0};

	typedef struct packed {
		hpio_cfg_t              cfg;
		logic [7:0]             firstOut;
		logic [7:0]             secondOut;
		logic [7:0]             thirdOut;
		logic [IRQ_WIDTH-1:0]   irqStat;
		logic [IRQ_WIDTH-1:0]   irqEn;
		logic [HSEN_WIDTH-1:0]  hsEn;
		logic [IRQ_WIDTH-1:0]   servPrev;
		logic [7:0]             rdData;
		hpio_pins_t             pinOut;
		hpio_pins_t             pinOeN;
		logic                   irq;
	} hpio_state_t;

	localparam hpio_state_t TOP_RESET = '{cfg: CFG_RESET,
		pinOeN: '{first: PORT_ALL, second: PORT_ALL, third: PORT_ALL}, default: '0};

endpackage : hpio_pkg

// *** hpio_top.sv ***
// Top of the handshake parallel I/O block: register port, port pins, third port mapping
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
module hpio_top
	import hpio_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic [ADDR_WIDTH-1:0] regAddr,
	input  wire logic [7:0]            regWrData,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [7:0]            regRdData,
	input  wire hpio_pins_t            pinIn,
	output hpio_pins_t                 pinOut,
	output hpio_pins_t                 pinOeN,
	output logic                       irq
);

	hpio_state_t s_q;
	hpio_state_t s_d;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode from the configuration word
	logic aStb;
	logic aBidir;
	logic aInStb;
	logic aOutStb;
	logic aBasic;
	logic bInStb;
	logic bOutStb;
	logic cfgWrite;
	logic firstRead;
	logic firstWrite;
	logic secondRead;
	logic secondWrite;

	assign aStb        = (s_q.cfg.aMode == MODE_STROBED);
	assign aBidir      = (s_q.cfg.aMode >= MODE_BIDIR);   // Unused code acts as bidirectional
	assign aBasic      = (s_q.cfg.aMode == MODE_BASIC);
	assign aInStb      = aStb && s_q.cfg.aIn;
	assign aOutStb     = aStb && !s_q.cfg.aIn;
	assign bInStb      = s_q.cfg.bMode && s_q.cfg.bIn;
	assign bOutStb     = s_q.cfg.bMode && !s_q.cfg.bIn;
	assign cfgWrite    = regWrite && (regAddr == ADDR_CONFIG);
	assign firstRead   = regRead && (regAddr == ADDR_FIRST);
	assign firstWrite  = regWrite && (regAddr == ADDR_FIRST);
	assign secondRead  = regRead && (regAddr == ADDR_SECOND);
	assign secondWrite = regWrite && (regAddr == ADDR_SECOND);

	////////////////////////////////////////////////////////////////////////////////
	// Handshake channels for the first and second port
	logic [7:0] aLatch;
	logic       aFull;
	logic       aOutFullN;
	logic       aSrv;
	logic [7:0] bLatch;
	logic       bFull;
	logic       bOutFullN;
	logic       bSrv;

	hpio_hs_chan #(
		.W         (PORT_WIDTH)
	) u_chan_a (
		.mclk      (mclk),
		.rst       (rst),
		.inMode    (aInStb || aBidir),
		.outMode   (aOutStb || aBidir),
		.inIe      (s_q.hsEn[HSEN_A_IN]),
		.outIe     (s_q.hsEn[HSEN_A_OUT]),
		.strobeN   (pinIn.third[C_A_STB]),
		.acceptN   (pinIn.third[C_A_ACK]),
		.pinData   (pinIn.first),
		.hostRead  (firstRead),
		.hostWrite (firstWrite),
		.clear     (cfgWrite),
		.latchData (aLatch),
		.inFull    (aFull),
		.outFullN  (aOutFullN),
		.servReq   (aSrv)
	);

	// The second port shares one pin for strobe and accept, chosen by its direction
	hpio_hs_chan #(
		.W         (PORT_WIDTH)
	) u_chan_b (
		.mclk      (mclk),
		.rst       (rst),
		.inMode    (bInStb),
		.outMode   (bOutStb),
		.inIe      (s_q.hsEn[HSEN_B]),
		.outIe     (s_q.hsEn[HSEN_B]),
		.strobeN   (pinIn.third[C_B_STRB]),
		.acceptN   (pinIn.third[C_B_STRB]),
		.pinData   (pinIn.second),
		.hostRead  (secondRead),
		.hostWrite (secondWrite),
		.clear     (cfgWrite),
		.latchData (bLatch),
		.inFull    (bFull),
		.outFullN  (bOutFullN),
		.servReq   (bSrv)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Third port line ownership and values
	logic [7:0] hsMask;
	logic [7:0] hsVal;
	logic [7:0] dirOutC;
	logic [7:0] thirdDrive;
	logic [7:0] thirdVal;
	logic [7:0] thirdRead;

	// Which lines the handshake modes take over
	assign hsMask = (aInStb ? MASK_A_IN : '0) | (aOutStb ? MASK_A_OUT : '0)
		| (aBidir ? MASK_A_BI : '0) | (s_q.cfg.bMode ? MASK_B : '0);

	// Handshake outputs placed at their line positions; input lines stay high here
	always_comb
	begin
		hsVal           = PORT_ALL;
		hsVal[C_A_OLF]  = aOutFullN;
		hsVal[C_A_ILF]  = aFull;
		hsVal[C_A_SRQ]  = aSrv;
		hsVal[C_B_FULL] = s_q.cfg.bIn ? bFull : bOutFullN;
		hsVal[C_B_SRQ]  = bSrv;
	end

	// Two halves with their own direction, handshake outputs always driven
	assign dirOutC    = {{HALF_WIDTH{!s_q.cfg.cHiIn}}, {HALF_WIDTH{!s_q.cfg.cLoIn}}};
	assign thirdDrive = (hsMask & HS_DRIVEN) | (~hsMask & dirOutC);
	assign thirdVal   = (hsMask & hsVal) | (~hsMask & s_q.thirdOut);
	assign thirdRead  = (hsMask & ((HS_DRIVEN & hsVal) | (~HS_DRIVEN & pinIn.third)))
		| (~hsMask & ((dirOutC & s_q.thirdOut) | (~dirOutC & pinIn.third)));

	////////////////////////////////////////////////////////////////////////////////
	// Port read data and pin drive of the first two ports
	logic [7:0]           firstVal;
	logic [7:0]           secondVal;
	logic                 aDrive;
	logic                 bDrive;
	logic [IRQ_WIDTH-1:0] servNow;
	logic [IRQ_WIDTH-1:0] servRise;

	// A latched port reads its latch; a basic input reads the pins directly
	assign firstVal  = (aInStb || aBidir) ? aLatch
		: ((aBasic && s_q.cfg.aIn) ? pinIn.first : s_q.firstOut);
	assign secondVal = bInStb ? bLatch
		: ((!s_q.cfg.bMode && s_q.cfg.bIn) ? pinIn.second : s_q.secondOut);

	// The bidirectional port drives only while the peer holds accept low
	assign aDrive = (aBasic && !s_q.cfg.aIn) || aOutStb
		|| (aBidir && !pinIn.third[C_A_ACK]);
	assign bDrive = !s_q.cfg.bIn;

	assign servNow          = {bSrv, aSrv};
	assign servRise         = servNow & ~s_q.servPrev;

	////////////////////////////////////////////////////////////////////////////////
	// Register file, interrupt status and registered pin drive
	always_comb
	begin
		s_d = s_q;
		s_d.servPrev = servNow;
		// Plain data writes; third port writes never reach handshake lines
		if (firstWrite)
			s_d.firstOut = regWrData;
		if (secondWrite)
			s_d.secondOut = regWrData;
		if (regWrite && (regAddr == ADDR_THIRD))
			s_d.thirdOut = (s_q.thirdOut & hsMask) | (regWrData & ~hsMask);
		if (regWrite && (regAddr == ADDR_IRQEN))
			s_d.irqEn = regWrData[IRQ_WIDTH-1:0];
		if (regWrite && (regAddr == ADDR_HSEN))
			s_d.hsEn = regWrData[HSEN_WIDTH-1:0];
		// Status bits stick; a new event wins over a clear in the same cycle
		s_d.irqStat = s_q.irqStat;
		if (regWrite && (regAddr == ADDR_IRQCLR))
			s_d.irqStat = s_q.irqStat & ~regWrData[IRQ_WIDTH-1:0];
		s_d.irqStat = s_d.irqStat | servRise;
		// A configuration write drops all held output data
		if (cfgWrite)
		begin
			s_d.cfg       = regWrData;
			s_d.firstOut  = '0;
			s_d.secondOut = '0;
			s_d.thirdOut  = '0;
		end
		// Read data stand for one cycle only
		s_d.rdData = '0;
		if (regRead)
		begin
			unique case (regAddr)
				ADDR_FIRST:   s_d.rdData = firstVal;
				ADDR_SECOND:  s_d.rdData = secondVal;
				ADDR_THIRD:   s_d.rdData = thirdRead;
				ADDR_CONFIG:  s_d.rdData = s_q.cfg;
				ADDR_IRQSTAT: s_d.rdData = {{(PORT_WIDTH-IRQ_WIDTH){1'b0}}, s_q.irqStat};
				ADDR_IRQCLR:  s_d.rdData = '0;
				ADDR_IRQEN:   s_d.rdData = {{(PORT_WIDTH-IRQ_WIDTH){1'b0}}, s_q.irqEn};
				ADDR_HSEN:    s_d.rdData = {{(PORT_WIDTH-HSEN_WIDTH){1'b0}}, s_q.hsEn};
			endcase
		end
		// Pins follow the state one cycle later so that every output is a flop
		s_d.pinOut.first   = s_q.firstOut;
		s_d.pinOut.second  = s_q.secondOut;
		s_d.pinOut.third   = thirdVal;
		s_d.pinOeN.first   = aDrive ? '0 : PORT_ALL;
		s_d.pinOeN.second  = bDrive ? '0 : PORT_ALL;
		s_d.pinOeN.third   = ~thirdDrive;
		s_d.irq            = |(s_d.irqStat & s_d.irqEn);
	end

	// State register, synchronous reset leaves every pin undriven
	always_ff @(posedge mclk)
	begin
		if (rst)
			s_q <= TOP_RESET;
		else
			s_q <= s_d;
	end

	assign regRdData = s_q.rdData;
	assign pinOut    = s_q.pinOut;
	assign pinOeN    = s_q.pinOeN;
	assign irq       = s_q.irq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks on register behaviour and third port mapping
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence cfgWritten;
		cfgWrite;
	endsequence

	sequence lowHalfWrite;
		regWrite && regAddr == ADDR_THIRD && aBasic && !s_q.cfg.bMode && !s_q.cfg.cLoIn
			&& !cfgWrite;
	endsequence

	a_cfg_clears: assert property (cfgWritten |=> s_q.firstOut == '0 && s_q.secondOut == '0
		&& s_q.thirdOut == '0 && s_q.cfg == $past(regWrData))
		else $error("config write kept output data");

	a_basic_read: assert property (regRead && regAddr == ADDR_FIRST && aBasic && s_q.cfg.aIn
		|=> regRdData == $past(pinIn.first))
		else $error("basic input read returned wrong data");

	a_read_once: assert property (regRead ##1 !regRead |=> regRdData == '0)
		else $error("read data held past one cycle");

	a_low_half: assert property (lowHalfWrite ##1 !cfgWrite |=> pinOut.third[3:0]
		== $past(regWrData[3:0], 2) && pinOeN.third[3:0] == '0)
		else $error("low half of third port not driven");

	a_hs_protect: assert property (regWrite && regAddr == ADDR_THIRD && aInStb && !cfgWrite
		|=> s_q.thirdOut[5:3] == $past(s_q.thirdOut[5:3]))
		else $error("write reached handshake lines");

	a_in_map: assert property (aInStb && !cfgWrite |=> pinOut.third[C_A_ILF] == $past(aFull)
		&& !pinOeN.third[C_A_ILF] && pinOeN.third[C_A_STB])
		else $error("strobed input mapping wrong");

	a_out_map: assert property (aOutStb && !cfgWrite |=> pinOut.third[C_A_OLF]
		== $past(aOutFullN) && pinOeN.third[C_A_ACK])
		else $error("strobed output mapping wrong");

	a_bidir_map: assert property (aBidir && !cfgWrite |=> pinOut.third[C_A_SRQ] == $past(aSrv)
		&& pinOeN.first == ($past(pinIn.third[C_A_ACK]) ? PORT_ALL : '0))
		else $error("bidirectional mapping wrong");

	a_irq_cause: assert property (irq |-> $past(|(servRise | s_q.irqStat)))
		else $error("interrupt without status event");

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the second port group, status bits and plain port drive
	sequence bInSel;
		bInStb && !cfgWrite;
	endsequence

	sequence bOutSel;
		bOutStb && !cfgWrite;
	endsequence

	// A clear that meets no new event in the same cycle
	sequence statClear;
		regWrite && regAddr == ADDR_IRQCLR && servRise == '0;
	endsequence

	a_b_in_map: assert property (bInSel |=>
		pinOut.third[C_B_FULL] == $past(bFull)
		&& !pinOeN.third[C_B_FULL] && pinOeN.third[C_B_STRB])
		else $error("second strobed input mapping wrong");

	a_b_out_map: assert property (bOutSel |=>
		pinOut.third[C_B_FULL] == $past(bOutFullN)
		&& !pinOeN.third[C_B_FULL] && pinOeN.third[C_B_STRB])
		else $error("second strobed output mapping wrong");

	a_b_srq_pin: assert property (s_q.cfg.bMode && !cfgWrite |=>
		pinOut.third[C_B_SRQ] == $past(bSrv) && !pinOeN.third[C_B_SRQ])
		else $error("second service pin wrong");

	a_b_read_latch: assert property (regRead && regAddr == ADDR_SECOND && bInStb |=>
		regRdData == $past(bLatch))
		else $error("second read missed latch");

	a_stat_set: assert property (servRise != '0 |=>
		(s_q.irqStat & $past(servRise)) == $past(servRise))
		else $error("event did not set status");

	a_stat_sticky: assert property (s_q.irqStat[IRQ_B]
		&& !(regWrite && regAddr == ADDR_IRQCLR && regWrData[IRQ_B]) |=> s_q.irqStat[IRQ_B])
		else $error("status dropped without clear");

	a_stat_clear: assert property (statClear |=>
		(s_q.irqStat & $past(regWrData[IRQ_WIDTH-1:0])) == '0)
		else $error("status clear ignored");

	a_clr_reads: assert property (regRead && regAddr == ADDR_IRQCLR |=>
		regRdData == '0)
		else $error("clear register read not zero");

	a_first_oe: assert property (aBasic && !cfgWrite |=>
		pinOeN.first == {PORT_WIDTH{$past(s_q.cfg.aIn)}})
		else $error("first drive ignores direction");

	a_second_oe: assert property (!cfgWrite |=>
		pinOeN.second == {PORT_WIDTH{$past(s_q.cfg.bIn)}})
		else $error("second drive ignores direction");

	a_second_lands: assert property (regWrite && regAddr == ADDR_SECOND |=>
		s_q.secondOut == $past(regWrData))
		else $error("second port write lost");

	a_cfg_read: assert property (regRead && regAddr == ADDR_CONFIG |=>
		regRdData == $past(s_q.cfg))
		else $error("config read wrong");

	a_third_pins: assert property (regRead && regAddr == ADDR_THIRD && aBasic
		&& !s_q.cfg.bMode && s_q.cfg.cHiIn && s_q.cfg.cLoIn |=> regRdData == $past(pinIn.third))
		else $error("third input read wrong");

	a_free_hi: assert property (aInStb && !cfgWrite |=>
		pinOeN.third[C_A_OLF] == $past(s_q.cfg.cHiIn)
		&& pinOeN.third[C_A_ACK] == $past(s_q.cfg.cHiIn))
		else $error("free upper lines ignore direction");

	a_bidir_free: assert property (aBidir && !cfgWrite |=>
		pinOeN.third[C_B_SRQ] == (!$past(s_q.cfg.bMode) && $past(s_q.cfg.cLoIn)))
		else $error("free lower line ignores direction");

endmodule : hpio_top

// *** hpio_top_tb.sv ***
// Self-checking testbench of the handshake parallel I/O block
`timescale 1ns/1ps
module hpio_top_tb
	import hpio_pkg::*;
;
	logic       mclk;
	logic       rst;
	logic [2:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrite;
	logic       regRead;
	logic [7:0] regRdData;
	hpio_pins_t pinIn;
	hpio_pins_t pinOut;
	hpio_pins_t pinOeN;
	hpio_pins_t drive;
	logic       irq;
	logic [3:0] ackDelay;
	int         error_cnt;
	int         n_tests;
	int         cycles;
	int         i;

	hpio_top u_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinIn(pinIn),
		.pinOut(pinOut), .pinOeN(pinOeN), .irq(irq));
	hpio_peer u_peer (.mclk(mclk), .pinOut(pinOut), .pinOeN(pinOeN), .drive(drive),
		.ackDelay(ackDelay), .pinIn(pinIn));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	// Settle past the edge so registered outputs have landed
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge mclk);
		regWrite  <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		chk(what, exp, regRdData);
	endtask : rd

	// One low cycle on a strobe or accept line of the third port
	task automatic strobe(input int b);
		@(posedge mclk);
		drive.third[b] <= 1'b0;
		@(posedge mclk);
		drive.third[b] <= 1'b1;
	endtask : strobe

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rd(ADDR_CONFIG, CFG_RESET, "config");
		rd(ADDR_THIRD, 8'hdf, "third in");
		chk("oe first", 8'hff, pinOeN.first);
		chk("irq", 8'h00, {7'h0, irq});
		$display("test reset done");
	endtask : t_reset

	task automatic t_basic();
		wr(ADDR_CONFIG, 8'h00);
		wr(ADDR_FIRST, 8'ha5);
		wr(ADDR_SECOND, 8'h3c);
		wr(ADDR_THIRD, 8'h5a);
		settle(1);
		chk("out first", 8'ha5, pinOut.first);
		chk("out second", 8'h3c, pinOut.second);
		chk("out third", 8'h5a, pinOut.third);
		chk("oe second", 8'h00, pinOeN.second);
		rd(ADDR_FIRST, 8'ha5, "rd first");
		// A new configuration must drop the output data
		wr(ADDR_CONFIG, 8'h08);
		wr(ADDR_THIRD, 8'h05);
		settle(1);
		chk("cleared", 8'h00, pinOut.first);
		chk("oe halves", 8'hf0, pinOeN.third);
		rd(ADDR_THIRD, 8'hd5, "rd halves");
		$display("test basic done");
	endtask : t_basic

	task automatic t_strobe_in();
		wr(ADDR_CONFIG, 8'h30);
		wr(ADDR_HSEN, 8'h01);
		wr(ADDR_IRQEN, 8'h01);
		wr(ADDR_THIRD, 8'hff);
		drive.first <= 8'h6b;
		settle(1);
		chk("free lines", 8'hc7, pinOut.third & 8'hef);
		chk("oe hs", 8'h10, pinOeN.third & 8'h38);
		strobe(C_A_STB);
		settle(2);
		chk("full req", 8'h28, pinOut.third & 8'h28);
		rd(ADDR_IRQSTAT, 8'h01, "status");
		chk("irq set", 8'h01, {7'h0, irq});
		rd(ADDR_FIRST, 8'h6b, "latch");
		settle(2);
		chk("full gone", 8'h00, pinOut.third & 8'h28);
		wr(ADDR_IRQEN, 8'h00);
		settle(2);
		chk("irq masked", 8'h00, {7'h0, irq});
		wr(ADDR_IRQCLR, 8'h01);
		wr(ADDR_IRQEN, 8'h01);
		settle(2);
		chk("irq clear", 8'h00, {7'h0, irq});
		$display("test strobed input done");
	endtask : t_strobe_in

	// Output transfers against a prompt and a slow receiver
	task automatic t_strobe_out();
		wr(ADDR_CONFIG, 8'h20);
		wr(ADDR_HSEN, 8'h02);
		settle(1);
		chk("full idle", 8'h80, pinOut.third & 8'h80);
		for (int d = 0; d < 8; d += 5)
		begin
			ackDelay <= 4'(d);
			wr(ADDR_FIRST, 8'h99 ^ 8'(d));
			settle(1);
			chk("full low", 8'h00, pinOut.third & 8'h80);
			chk("data", 8'h99 ^ 8'(d), pinOut.first);
			for (i = 0; i < 20 && pinOut.third[C_A_OLF] !== 1'b1; i++)
				settle(1);
			chk("accepted", 8'h80, pinOut.third & 8'h80);
		end
		$display("test strobed output done");
	endtask : t_strobe_out

	task automatic t_bidir();
		wr(ADDR_CONFIG, 8'h40);
		drive.first <= 8'hc3;
		settle(1);
		chk("oe idle", 8'hff, pinOeN.first);
		strobe(C_A_STB);
		settle(2);
		chk("bi full", 8'h20, pinOut.third & 8'h20);
		rd(ADDR_FIRST, 8'hc3, "bi latch");
		ackDelay <= 4'h2;
		wr(ADDR_FIRST, 8'h5a);
		for (i = 0; i < 20 && pinOeN.first !== 8'h00; i++)
			settle(1);
		chk("bi drive", 8'h00, pinOeN.first);
		chk("bi data", 8'h5a, pinOut.first);
		for (i = 0; i < 20 && pinOeN.first !== 8'hff; i++)
			settle(1);
		chk("bi release", 8'hff, pinOeN.first);
		$display("test bidirectional done");
	endtask : t_bidir

	// Second port group: strobed input, then strobed output on the shared line
	task automatic t_second();
		wr(ADDR_CONFIG, 8'h06);
		wr(ADDR_HSEN, 8'h04);
		wr(ADDR_IRQCLR, 8'h03);
		drive.second <= 8'h4e;
		settle(1);
		chk("oe b hs", 8'h04, pinOeN.third & 8'h07);
		strobe(C_B_STRB);
		settle(2);
		chk("b full req", 8'h03, pinOut.third & 8'h03);
		rd(ADDR_IRQSTAT, 8'h02, "status b");
		rd(ADDR_SECOND, 8'h4e, "latch b");
		rd(ADDR_IRQCLR, 8'h00, "clear reads");
		wr(ADDR_CONFIG, 8'h04);
		wr(ADDR_SECOND, 8'h81);
		settle(1);
		chk("b out full", 8'h00, pinOut.third & 8'h02);
		chk("b data", 8'h81, pinOut.second);
		strobe(C_B_STRB);
		settle(1);
		chk("b accepted", 8'h02, pinOut.third & 8'h02);
		$display("test second port done");
	endtask : t_second

	////////////////////////////////////////////////////////////////////////////////
	// Clock, hang guard and main sequence
	always #2 mclk = ~mclk;

	// A hang counts as a mismatch and ends the run
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	initial
	begin
		mclk      = 1'b0;
		rst       = 1'b1;
		regAddr   = 3'h0;
		regWrData = 8'h00;
		regWrite  = 1'b0;
		regRead   = 1'b0;
		ackDelay  = 4'h0;
		drive     = '{first: 8'h00, second: 8'h00, third: 8'hdf};
		error_cnt = 0;
		n_tests   = 0;
		cycles    = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_basic();
		t_strobe_in();
		t_strobe_out();
		t_bidir();
		t_second();
		stop_test();
	end
endmodule : hpio_top_tb
